/* meas_pkg.sv */
// constants, register map and carrier types of the range, filter and scaling block
// assumes samples arrive already calibrated, in normalized units of the selected range
package meas_pkg;

	localparam int CHANNELS = 8;
	localparam int CHAN_W   = 3;
	localparam int SAMPLE_W = 16;
	localparam int FRAC_W   = 8;
	localparam int STATE_W  = SAMPLE_W + FRAC_W;
	localparam int ADDR_W   = 7;
	localparam int DATA_W   = 16;
	localparam int MATH_W   = 34;

	// range codes; only the plus/minus ten volt range is bipolar
	localparam logic [2:0] RANGE_BIP_10V   = 3'h0;
	localparam logic [2:0] RANGE_0_10V     = 3'h1;
	localparam logic [2:0] RANGE_0_5V      = 3'h2;
	localparam logic [2:0] RANGE_1_5V      = 3'h3;
	localparam logic [2:0] RANGE_0_20MA    = 3'h4;
	localparam logic [2:0] RANGE_4_20MA    = 3'h5;
	localparam logic [2:0] RANGE_LAST      = 3'h5;

	// normalized range ends, spans and limits
	localparam logic signed [MATH_W-1:0] NORM_MAX      = 34'sh0_0000_2710;
	localparam logic signed [MATH_W-1:0] NORM_MIN_BIP  = -34'sh0_0000_2710;
	localparam logic signed [MATH_W-1:0] NORM_MIN_UNI  = 34'sh0_0000_0000;
	localparam logic signed [MATH_W-1:0] SPAN_UNI      = 34'sh0_0000_2710;
	localparam logic signed [MATH_W-1:0] SPAN_BIP      = 34'sh0_0000_4E20;
	localparam logic signed [MATH_W-1:0] USER_LIMIT    = 34'sh0_0000_7530;
	localparam logic [DATA_W-1:0]        TOL_DEFAULT   = 16'h04E2;
	localparam logic [DATA_W-1:0]        TOL_MAX       = 16'h09C4;
	localparam logic signed [DATA_W-1:0] USER_LIM16    = 16'sh7530;
	localparam logic signed [DATA_W-1:0] USER_MIN_DEF  = 16'sh0000;
	localparam logic signed [DATA_W-1:0] USER_MAX_DEF  = 16'sh2710;

	// filter setting 0 disables, n selects alpha = 1 - 2^-(n+1)
	localparam logic [2:0] FILT_OFF  = 3'h0;
	localparam logic [2:0] FILT_LAST = 3'h6;

	typedef enum logic [1:0] {
		MON_FULL   = 2'h0,
		MON_LIMITS = 2'h1,
		MON_OFF    = 2'h2
	} monitor_t;

	// configuration word layout, high bits first
	typedef struct packed {
		logic       in_use;
		logic       user_disp;
		logic [2:0] filt;
		monitor_t   mon;
		logic [2:0] range;
	} chan_cfg_t;

	localparam int          CFG_W       = 10;
	localparam chan_cfg_t   CFG_RESET   = '{in_use: 1'b1, user_disp: 1'b0, filt: 3'h0,
	                                        mon: MON_FULL, range: 3'h0};

	typedef struct packed {
		logic under;
		logic over;
		logic low_tol;
		logic up_tol;
	} chan_flags_t;

	// register map: address [6] selects global, [5:3] channel, [2:0] register
	localparam logic [2:0] REG_CFG      = 3'h0;
	localparam logic [2:0] REG_LOW_TOL  = 3'h1;
	localparam logic [2:0] REG_UP_TOL   = 3'h2;
	localparam logic [2:0] REG_USER_MIN = 3'h3;
	localparam logic [2:0] REG_USER_MAX = 3'h4;
	localparam logic [2:0] REG_VALUE    = 3'h5;
	localparam logic [2:0] REG_STATUS   = 3'h6;
	localparam logic [2:0] REG_DIAG     = 3'h7;
	localparam logic [ADDR_W-1:0] REG_GLOBAL    = 7'h40;
	localparam logic [ADDR_W-1:0] REG_FAULT_SUM = 7'h41;
	localparam int GLOBAL_SEL_BIT = 6;
	localparam int FAST_BIT       = 0;

	// status and diagnostic bit positions
	localparam int STATUS_LOW_TOL_BIT = 5;
	localparam int STATUS_UP_TOL_BIT  = 6;
	localparam int DIAG_VIOL_BIT      = 1;
	localparam int DIAG_UNDER_BIT     = 14;
	localparam int DIAG_OVER_BIT      = 15;

endpackage : meas_pkg

/* first_order_filter.sv */
// one step of the recursive filter for the channel whose state is presented
// assumes the caller holds the per-channel state and writes next_state_o back
`timescale 1ns/1ns
module first_order_filter (
	// present state and sample
	input  wire logic signed [meas_pkg::STATE_W-1:0]  state_i,
	input  wire logic signed [meas_pkg::SAMPLE_W-1:0] sample_i,
	// control
	input  wire logic [2:0]                           setting_i,
	input  wire logic                                 load_i,
	// result
	output logic signed [meas_pkg::STATE_W-1:0]       next_state_o,
	output logic signed [meas_pkg::SAMPLE_W-1:0]      out_o
);

	logic signed [meas_pkg::STATE_W:0]   wide_x;
	logic signed [meas_pkg::STATE_W:0]   diff;
	logic signed [meas_pkg::STATE_W:0]   step;
	logic signed [meas_pkg::STATE_W:0]   sum;
	logic signed [meas_pkg::STATE_W:0]   rounded;
	logic [2:0]                          shift;

	always_comb begin
		wide_x = {sample_i[meas_pkg::SAMPLE_W-1], sample_i, {meas_pkg::FRAC_W{1'b0}}};
		diff   = wide_x - {state_i[meas_pkg::STATE_W-1], state_i};
		shift  = setting_i + 3'h1;
		// alpha = 1 - 2^-shift, so y += (x - y) >> shift
		step   = diff >>> shift;
		sum    = {state_i[meas_pkg::STATE_W-1], state_i} + step;
		// round to nearest on the way out
		rounded = sum + (meas_pkg::STATE_W+1)'(1 << (meas_pkg::FRAC_W - 1));
		if (load_i || setting_i == meas_pkg::FILT_OFF || setting_i > meas_pkg::FILT_LAST) begin
			next_state_o = wide_x[meas_pkg::STATE_W-1:0];
			out_o        = sample_i;
		end else begin
			next_state_o = sum[meas_pkg::STATE_W-1:0];
			out_o        = rounded[meas_pkg::STATE_W-1:meas_pkg::FRAC_W];
		end
	end

endmodule : first_order_filter

/* measurement_range_filter_scale.sv */
// per-channel filtering, range monitoring with clamping, and display scaling
// assumes one calibrated sample per cycle at most, on sys_clk_i, in normalized units
//
// Behaviour
// - each channel picks one of six ranges; processing follows that range
// - with monitoring on, each measurement is compared to lower and upper thresholds
// - five areas: underflow, lower tolerance, nominal, upper tolerance, overflow
// - status bit 5 is high while in the lower tolerance area
// - status bit 6 is high while in the upper tolerance area
// - limit monitoring sets diag bit 1, bit 14 or 15, and the fault flag
// - under or overflow clamps the value to the crossed threshold
// - thresholds configured separately and limited to their tolerance bounds
// - tolerance width default 1250, adjustable 0 to 2500 normalized units
// - only plus/minus ten volt is bipolar, other ranges unipolar
// - monitoring modes: full by default, limits only, or off
// - first-order recursive filter y = a*y + (1-a)*x
// - seven settings, 0 off, 1 to 6 alpha from 0.750 to 0.992
// - filter setting may change at any time; a write to any of channel registers 0 to 4 restarts that channel's filter
// - fast cycle bypasses the filter on all channels
// - standard display 0..10000 unipolar, -10000..+10000 bipolar
// - user display maps range ends to limits within -30000..+30000
// - fast cycle handles only channels marked in use
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
module measurement_range_filter_scale (
	// clock and reset
	input  wire logic                                 sys_clk_i,
	input  wire logic                                 rstn_i,
	// sample stream from the converter
	input  wire logic                                 sample_valid_i,
	input  wire logic [meas_pkg::CHAN_W-1:0]          sample_chan_i,
	input  wire logic signed [meas_pkg::SAMPLE_W-1:0] sample_data_i,
	// processed result stream
	output logic                                      result_valid_o,
	output logic [meas_pkg::CHAN_W-1:0]               result_chan_o,
	output logic signed [meas_pkg::DATA_W-1:0]        result_value_o,
	output logic [meas_pkg::CHANNELS-1:0]             channel_fault_flag_o,
	// register port
	input  wire logic [meas_pkg::ADDR_W-1:0]          reg_addr_i,
	input  wire logic [meas_pkg::DATA_W-1:0]          reg_wdata_i,
	input  wire logic                                 reg_wr_i,
	input  wire logic                                 reg_rd_i,
	output logic [meas_pkg::DATA_W-1:0]               reg_rdata_o
);

	localparam int N  = meas_pkg::CHANNELS;
	localparam int MW = meas_pkg::MATH_W;

	logic [1:0]                              rst_sync;
	logic                                    rst_n;

	meas_pkg::chan_cfg_t                     cfg [N];
	logic [meas_pkg::DATA_W-1:0]             low_tol [N];
	logic [meas_pkg::DATA_W-1:0]             up_tol [N];
	logic signed [meas_pkg::DATA_W-1:0]      user_min [N];
	logic signed [meas_pkg::DATA_W-1:0]      user_max [N];
	logic signed [meas_pkg::DATA_W-1:0]      value [N];
	meas_pkg::chan_flags_t                   flags [N];
	logic signed [meas_pkg::STATE_W-1:0]     fstate [N];
	logic [N-1:0]                            primed;
	logic                                    fast;

	logic                                    accept;
	logic signed [meas_pkg::STATE_W-1:0]     next_state;
	logic signed [meas_pkg::SAMPLE_W-1:0]    filt_out;
	logic                                    a_valid;
	logic [meas_pkg::CHAN_W-1:0]             a_chan;
	logic signed [meas_pkg::SAMPLE_W-1:0]    a_value;

	logic                                    wr_chan;
	logic [meas_pkg::CHAN_W-1:0]             wr_idx;
	logic [2:0]                              wr_reg;
	logic                                    cfg_write;
	logic                                    fast_leave;

	logic signed [MW-1:0]                    v;
	logic signed [MW-1:0]                    rmin;
	logic signed [MW-1:0]                    span;
	logic signed [MW-1:0]                    lo_th;
	logic signed [MW-1:0]                    hi_th;
	logic signed [MW-1:0]                    clamped;
	logic signed [MW-1:0]                    num;
	logic signed [MW-1:0]                    quot;
	logic signed [MW-1:0]                    scaled;
	logic signed [meas_pkg::DATA_W-1:0]      next_value;
	meas_pkg::chan_flags_t                   next_flags;
	logic                                    below;
	logic                                    above;
	logic                                    limits_on;

	function automatic logic is_bipolar(input logic [2:0] range);
		return range == meas_pkg::RANGE_BIP_10V;
	endfunction : is_bipolar

	function automatic logic signed [meas_pkg::DATA_W-1:0] sat16(
		input logic signed [MW-1:0] x,
		input logic signed [MW-1:0] lim
	);
		logic signed [MW-1:0] r;
		r = x;
		if (x > lim) begin
			r = lim;
		end else if (x < -lim) begin
			r = -lim;
		end
		return r[meas_pkg::DATA_W-1:0];
	endfunction : sat16

	function automatic logic [meas_pkg::DATA_W-1:0] limit_tol(input logic [meas_pkg::DATA_W-1:0] x);
		logic signed [meas_pkg::DATA_W-1:0] s;
		s = $signed(x);
		if (s < 0) begin
			return '0;
		end
		return (x > meas_pkg::TOL_MAX) ? meas_pkg::TOL_MAX : x;
	endfunction : limit_tol

	// reset release through two flip-flops
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// register decode
	assign wr_chan    = reg_wr_i && !reg_addr_i[meas_pkg::GLOBAL_SEL_BIT];
	assign wr_idx     = reg_addr_i[5:3];
	assign wr_reg     = reg_addr_i[2:0];
	assign cfg_write  = wr_chan && wr_reg <= meas_pkg::REG_USER_MAX;
	assign fast_leave = reg_wr_i && reg_addr_i == meas_pkg::REG_GLOBAL && fast
	                    && !reg_wdata_i[meas_pkg::FAST_BIT];

	// channel configuration
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				cfg[i]      <= meas_pkg::CFG_RESET;
				low_tol[i]  <= meas_pkg::TOL_DEFAULT;
				up_tol[i]   <= meas_pkg::TOL_DEFAULT;
				user_min[i] <= meas_pkg::USER_MIN_DEF;
				user_max[i] <= meas_pkg::USER_MAX_DEF;
			end
		end else if (wr_chan) begin
			unique case (wr_reg)
				meas_pkg::REG_CFG: begin
					// filter setting takes effect on the next sample
					cfg[wr_idx].filt      <= reg_wdata_i[7:5];
					cfg[wr_idx].user_disp <= reg_wdata_i[8];
					cfg[wr_idx].in_use    <= reg_wdata_i[9];
					cfg[wr_idx].mon       <= (reg_wdata_i[4:3] == 2'h3) ? meas_pkg::MON_OFF
					                         : meas_pkg::monitor_t'(reg_wdata_i[4:3]);
					if (reg_wdata_i[2:0] <= meas_pkg::RANGE_LAST) begin
						cfg[wr_idx].range <= reg_wdata_i[2:0];
					end
				end
				meas_pkg::REG_LOW_TOL:  low_tol[wr_idx]  <= limit_tol(reg_wdata_i);
				meas_pkg::REG_UP_TOL:   up_tol[wr_idx]   <= limit_tol(reg_wdata_i);
				meas_pkg::REG_USER_MIN: user_min[wr_idx] <= sat16(MW'($signed(reg_wdata_i)),
				                                                  meas_pkg::USER_LIMIT);
				meas_pkg::REG_USER_MAX: user_max[wr_idx] <= sat16(MW'($signed(reg_wdata_i)),
				                                                  meas_pkg::USER_LIMIT);
				default: begin
				end
			endcase
		end
	end

	// global cycle mode
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fast <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == meas_pkg::REG_GLOBAL) begin
			fast <= reg_wdata_i[meas_pkg::FAST_BIT];
		end
	end

	// stage one: filtering
	assign accept = sample_valid_i && (!fast || cfg[sample_chan_i].in_use);

	first_order_filter u_filter (
		.state_i      (fstate[sample_chan_i]),
		.sample_i     (sample_data_i),
		.setting_i    (cfg[sample_chan_i].filt),
		.load_i       (fast || !primed[sample_chan_i]),
		.next_state_o (next_state),
		.out_o        (filt_out)
	);

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				fstate[i] <= '0;
			end
		end else if (accept) begin
			fstate[sample_chan_i] <= next_state;
		end
	end

	// restart wins over a sample in the same cycle
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			primed <= '0;
		end else begin
			for (int i = 0; i < N; i++) begin
				if (fast_leave || (cfg_write && wr_idx == i[meas_pkg::CHAN_W-1:0])) begin
					primed[i] <= 1'b0;
				end else if (accept && !fast && sample_chan_i == i[meas_pkg::CHAN_W-1:0]) begin
					primed[i] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			a_valid <= 1'b0;
			a_chan  <= '0;
			a_value <= '0;
		end else begin
			a_valid <= accept;
			if (accept) begin
				a_chan  <= sample_chan_i;
				a_value <= (fast) ? sample_data_i : filt_out;
			end
		end
	end

	// stage two: areas, clamping and scaling
	always_comb begin
		v         = MW'(a_value);
		rmin      = is_bipolar(cfg[a_chan].range) ? meas_pkg::NORM_MIN_BIP
		                                          : meas_pkg::NORM_MIN_UNI;
		span      = is_bipolar(cfg[a_chan].range) ? meas_pkg::SPAN_BIP : meas_pkg::SPAN_UNI;
		lo_th     = rmin - MW'(low_tol[a_chan]);
		hi_th     = meas_pkg::NORM_MAX + MW'(up_tol[a_chan]);
		below     = v < lo_th;
		above     = v > hi_th;
		limits_on = cfg[a_chan].mon != meas_pkg::MON_OFF;
		next_flags.under   = limits_on && below;
		next_flags.over    = limits_on && above;
		next_flags.low_tol = cfg[a_chan].mon == meas_pkg::MON_FULL && !below && v < rmin;
		next_flags.up_tol  = cfg[a_chan].mon == meas_pkg::MON_FULL && !above
		                     && v > meas_pkg::NORM_MAX;
		clamped   = v;
		if (next_flags.under) begin
			clamped = lo_th;
		end else if (next_flags.over) begin
			clamped = hi_th;
		end
		// user scale: umin + (x - rmin) * (umax - umin) / span, rounded to nearest
		num       = (clamped - rmin) * (MW'(user_max[a_chan]) - MW'(user_min[a_chan]));
		quot      = (num + ((num < 0) ? -(span >>> 1) : (span >>> 1))) / span;
		scaled    = MW'(user_min[a_chan]) + quot;
		if (cfg[a_chan].user_disp) begin
			next_value = sat16(scaled, meas_pkg::USER_LIMIT);
		end else begin
			next_value = sat16(clamped, MW'(16'sh7FFF));
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < N; i++) begin
				value[i] <= '0;
				flags[i] <= '0;
			end
		end else if (a_valid) begin
			value[a_chan] <= next_value;
			flags[a_chan] <= next_flags;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			result_valid_o <= 1'b0;
			result_chan_o  <= '0;
			result_value_o <= '0;
		end else begin
			result_valid_o <= a_valid;
			if (a_valid) begin
				result_chan_o  <= a_chan;
				result_value_o <= next_value;
			end
		end
	end

	generate
		for (genvar g = 0; g < N; g++) begin : g_fault
			assign channel_fault_flag_o[g] = flags[g].under || flags[g].over;
		end
	endgenerate

	// read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= '0;
			if (reg_addr_i == meas_pkg::REG_GLOBAL) begin
				reg_rdata_o[meas_pkg::FAST_BIT] <= fast;
			end else if (reg_addr_i == meas_pkg::REG_FAULT_SUM) begin
				reg_rdata_o[N-1:0] <= channel_fault_flag_o;
			end else if (!reg_addr_i[meas_pkg::GLOBAL_SEL_BIT]) begin
				unique case (reg_addr_i[2:0])
					meas_pkg::REG_CFG:      reg_rdata_o[meas_pkg::CFG_W-1:0] <= cfg[reg_addr_i[5:3]];
					meas_pkg::REG_LOW_TOL:  reg_rdata_o <= low_tol[reg_addr_i[5:3]];
					meas_pkg::REG_UP_TOL:   reg_rdata_o <= up_tol[reg_addr_i[5:3]];
					meas_pkg::REG_USER_MIN: reg_rdata_o <= user_min[reg_addr_i[5:3]];
					meas_pkg::REG_USER_MAX: reg_rdata_o <= user_max[reg_addr_i[5:3]];
					meas_pkg::REG_VALUE:    reg_rdata_o <= value[reg_addr_i[5:3]];
					meas_pkg::REG_STATUS: begin
						reg_rdata_o[meas_pkg::STATUS_LOW_TOL_BIT] <= flags[reg_addr_i[5:3]].low_tol;
						reg_rdata_o[meas_pkg::STATUS_UP_TOL_BIT]  <= flags[reg_addr_i[5:3]].up_tol;
					end
					meas_pkg::REG_DIAG: begin
						reg_rdata_o[meas_pkg::DIAG_VIOL_BIT]  <= channel_fault_flag_o[reg_addr_i[5:3]];
						reg_rdata_o[meas_pkg::DIAG_UNDER_BIT] <= flags[reg_addr_i[5:3]].under;
						reg_rdata_o[meas_pkg::DIAG_OVER_BIT]  <= flags[reg_addr_i[5:3]].over;
					end
				endcase
			end
		end
	end

endmodule : measurement_range_filter_scale

/* host_cpu_model.sv */
// host controller model driving the register port of the block
// assumes callers enter its tasks just after a rising clock edge
`timescale 1ns/1ns
module host_cpu_model (
	// clock
	input  wire logic        clk_i,
	// register port
	output logic [6:0]       addr_o,
	output logic [15:0]      wdata_o,
	output logic             wr_o,
	output logic             rd_o,
	input  wire logic [15:0] rdata_i
);
	initial begin
		addr_o = 7'h00;
		wdata_o = 16'h0000;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		#1;
	endtask : wr
	// read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [6:0] a, output logic [15:0] d);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask : rd
endmodule : host_cpu_model

/* measurement_range_filter_scale_asserts.sv */
// checker of the range, filter and scaling block, sees only its top ports
// assumes the fast cycle bit changes only by a write to the global register
`timescale 1ns/1ns
module measurement_range_filter_scale_asserts (
	// clock and reset
	input wire logic                                 sys_clk_i,
	input wire logic                                 rstn_i,
	// sample stream
	input wire logic                                 sample_valid_i,
	input wire logic [meas_pkg::CHAN_W-1:0]          sample_chan_i,
	input wire logic signed [meas_pkg::SAMPLE_W-1:0] sample_data_i,
	// result stream
	input wire logic                                 result_valid_o,
	input wire logic [meas_pkg::CHAN_W-1:0]          result_chan_o,
	input wire logic signed [meas_pkg::DATA_W-1:0]   result_value_o,
	input wire logic [meas_pkg::CHANNELS-1:0]        channel_fault_flag_o,
	// register port
	input wire logic [meas_pkg::ADDR_W-1:0]          reg_addr_i,
	input wire logic [meas_pkg::DATA_W-1:0]          reg_wdata_i,
	input wire logic                                 reg_wr_i,
	input wire logic                                 reg_rd_i,
	input wire logic [meas_pkg::DATA_W-1:0]          reg_rdata_o
);
	logic fast_q;
	always_ff @(posedge sys_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			fast_q <= 1'b0;
		end else if (reg_wr_i && reg_addr_i == meas_pkg::REG_GLOBAL) begin
			fast_q <= reg_wdata_i[meas_pkg::FAST_BIT];
		end
	end
	function automatic logic [15:0] tol_clamp(input logic [15:0] d);
		return d[15] ? 16'h0000 : (d > meas_pkg::TOL_MAX) ? meas_pkg::TOL_MAX : d;
	endfunction : tol_clamp
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_tol_wr;
		reg_wr_i && !reg_addr_i[6] && reg_addr_i[2:0] inside {3'h1, 3'h2};
	endsequence
	sequence s_tol_rd;
		reg_rd_i && reg_addr_i == $past(reg_addr_i);
	endsequence
	a_result_delay: assert property (sample_valid_i && !fast_q |-> ##2 result_valid_o)
		else $error("result missing two cycles after sample");
	a_result_chan: assert property (sample_valid_i && !fast_q |->
		##2 result_chan_o == $past(sample_chan_i, 2)) else $error("result channel wrong");
	a_result_cause: assert property (result_valid_o |-> $past(sample_valid_i, 2))
		else $error("result without a sample");
	a_value_hold: assert property (!result_valid_o |-> $stable(result_value_o))
		else $error("value changed without a result");
	a_fault_own: assert property (((channel_fault_flag_o ^ $past(channel_fault_flag_o))
		& ~({7'h00, result_valid_o} << result_chan_o)) == 8'h00) else $error("fault flag moved");
	a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
		else $error("read data changed without a read");
	a_fault_sum: assert property (reg_rd_i && reg_addr_i == meas_pkg::REG_FAULT_SUM |=>
		reg_rdata_o == {8'h00, $past(channel_fault_flag_o)}) else $error("fault summary wrong");
	a_tol_clamp: assert property (s_tol_wr ##1 s_tol_rd |=>
		reg_rdata_o == tol_clamp($past(reg_wdata_i, 2))) else $error("tolerance not limited");
endmodule : measurement_range_filter_scale_asserts
bind measurement_range_filter_scale measurement_range_filter_scale_asserts u_chk (
	.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sample_valid_i(sample_valid_i),
	.sample_chan_i(sample_chan_i), .sample_data_i(sample_data_i), .result_valid_o(result_valid_o),
	.result_chan_o(result_chan_o), .result_value_o(result_value_o),
	.channel_fault_flag_o(channel_fault_flag_o), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o)
);

/* measurement_range_filter_scale_tb.sv */
// self-checking bench: table, corner and seeded random samples, host model on registers
// assumes the package constants and the hand-over timing of both ports
`timescale 1ns/1ns
`define CHK(g, e) begin \
	checked++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
	end \
end
module measurement_range_filter_scale_tb;
	logic               sys_clk;
	logic               rstn;
	logic               s_valid;
	logic [2:0]         s_chan;
	logic signed [15:0] s_data;
	logic               r_valid;
	logic [2:0]         r_chan;
	logic signed [15:0] r_value;
	logic [7:0]         fault;
	logic [6:0]         addr;
	logic [15:0]        wdata;
	logic [15:0]        rdata;
	logic [15:0]        rd_val;
	logic               wr;
	logic               rd;
	int                 errors;
	int                 checked;
	int                 vals[6] = '{-12000, -10500, -500, 5000, 10500, 12000};

	measurement_range_filter_scale u_dut (
		.sys_clk_i(sys_clk), .rstn_i(rstn), .sample_valid_i(s_valid), .sample_chan_i(s_chan),
		.sample_data_i(s_data), .result_valid_o(r_valid), .result_chan_o(r_chan),
		.result_value_o(r_value), .channel_fault_flag_o(fault), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata));
	host_cpu_model u_host (.clk_i(sys_clk), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// expected value and flags {under, over, low tol, up tol} at default tolerances
	function automatic logic signed [15:0] expect_val(input logic bip, input logic [1:0] m,
		input int x, output logic [3:0] fl);
		int rmin;
		rmin = bip ? -10000 : 0;
		fl = {x < rmin - 1250, x > 11250, m == 2'h0 && x >= rmin - 1250 && x < rmin,
			m == 2'h0 && x > 10000 && x <= 11250};
		if (m == 2'h2) fl = 4'h0;
		if (fl[3]) x = rmin - 1250;
		if (fl[2]) x = 11250;
		return 16'(x);
	endfunction : expect_val

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic w(input logic [2:0] c, input logic [2:0] r, input logic [15:0] d);
		u_host.wr({1'b0, c, r}, d);
	endtask : w

	task automatic rc(input logic [2:0] c, input logic [2:0] r, input logic [15:0] e);
		logic [15:0] d;
		u_host.rd({1'b0, c, r}, d);
		`CHK(d, e)
	endtask : rc

	task automatic send(input logic [2:0] c, input logic signed [15:0] d);
		int n;
		@(posedge sys_clk);
		s_valid <= 1'b1;
		s_chan <= c;
		s_data <= d;
		@(posedge sys_clk);
		s_valid <= 1'b0;
		s_data <= ~d;
		#1;
		n = 0;
		while (r_valid !== 1'b1 && n < 8) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		`CHK(n, 1)
		if (n == 8) final_report();
		`CHK(r_chan, c)
	endtask : send

	task automatic area(input logic [2:0] c, input logic bip, input logic [1:0] m, input int x);
		logic [3:0] fl;
		logic signed [15:0] ev;
		ev = expect_val(bip, m, x, fl);
		send(c, 16'(x));
		`CHK(r_value, ev)
		`CHK(fault[c], fl[3] | fl[2])
		rc(c, meas_pkg::REG_STATUS, {9'h000, fl[0], fl[1], 5'h00});
		rc(c, meas_pkg::REG_DIAG, {fl[2], fl[3], 12'h000, fl[3] | fl[2], 1'b0});
	endtask : area

	initial begin
		rstn = 1'b0;
		s_valid = 1'b0;
		s_chan = 3'h0;
		s_data = 16'sh0000;
		errors = 0;
		checked = 0;
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		void'($urandom(21254));
		rc(3'h0, meas_pkg::REG_CFG, 16'h0200);
		rc(3'h0, meas_pkg::REG_LOW_TOL, meas_pkg::TOL_DEFAULT);
		rc(3'h0, meas_pkg::REG_USER_MAX, 16'h2710);
		w(3'h0, meas_pkg::REG_LOW_TOL, 16'h0BB8);
		rc(3'h0, meas_pkg::REG_LOW_TOL, meas_pkg::TOL_MAX);
		w(3'h0, meas_pkg::REG_UP_TOL, 16'hFFFF);
		rc(3'h0, meas_pkg::REG_UP_TOL, 16'h0000);
		w(3'h0, meas_pkg::REG_CFG, 16'h0206);
		rc(3'h0, meas_pkg::REG_CFG, 16'h0200);
		w(3'h0, meas_pkg::REG_CFG, 16'h0218);
		rc(3'h0, meas_pkg::REG_CFG, 16'h0210);
		u_host.rd(7'h42, rd_val);
		`CHK(rd_val, 16'h0000)
		$display("test registers done");
		for (int r = 0; r < 6; r++) begin
			for (int m = 0; m < 3; m++) begin
				w(3'h1, meas_pkg::REG_CFG, 16'(32'h0200 | (m << 3) | r));
				foreach (vals[i]) area(3'h1, r == 0, 2'(m), vals[i]);
			end
		end
		u_host.rd(meas_pkg::REG_FAULT_SUM, rd_val);
		`CHK(rd_val, {8'h00, fault})
		for (int k = 0; k < 40; k++) area(3'h6, 1'b1, 2'h0, int'($urandom_range(30000)) - 15000);
		$display("test areas done");
		for (int n = 0; n < 7; n++) begin
			w(3'h3, meas_pkg::REG_CFG, 16'(32'h0200 | (n << 5)));
			send(3'h3, 16'sh0000);
			send(3'h3, 16'sh0400);
			`CHK(r_value, (n == 0) ? 16'sh0400 : 16'(1024 >> (n + 1)))
		end
		u_host.wr(meas_pkg::REG_GLOBAL, 16'h0001);
		send(3'h3, 16'sh0000);
		send(3'h3, 16'sh0400);
		`CHK(r_value, 16'sh0400)
		w(3'h4, meas_pkg::REG_CFG, 16'h0000);
		@(posedge sys_clk);
		s_valid <= 1'b1;
		s_chan <= 3'h4;
		s_data <= 16'sh1000;
		@(posedge sys_clk);
		s_valid <= 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK(r_chan, 3'h3)
		rc(3'h4, meas_pkg::REG_VALUE, 16'h0000);
		u_host.wr(meas_pkg::REG_GLOBAL, 16'h0000);
		send(3'h3, 16'sh0400);
		`CHK(r_value, 16'sh0400)
		send(3'h3, 16'sh0000);
		`CHK(r_value, 16'sh03F8)
		$display("test filter done");
		w(3'h5, meas_pkg::REG_CFG, 16'h0301);
		w(3'h5, meas_pkg::REG_USER_MIN, 16'h0C80);
		w(3'h5, meas_pkg::REG_USER_MAX, 16'h2580);
		send(3'h5, 16'sh1388);
		`CHK(r_value, 16'sh1900)
		send(3'h5, 16'sh2710);
		`CHK(r_value, 16'sh2580)
		w(3'h5, meas_pkg::REG_USER_MAX, 16'h8000);
		rc(3'h5, meas_pkg::REG_USER_MAX, 16'h8AD0);
		$display("test user display done");
		final_report();
	end
endmodule : measurement_range_filter_scale_tb
